// ===== src/scp_pkg.sv
/*
  Constants and types of the serial configuration port.
  Assumes a 40 MHz core clock and a 200 ns configuration clock period.
*/
package scp_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CFG_HALF_NS = 100;
  localparam int CFG_HALF_CYC_INT = CFG_HALF_NS / CLK_PERIOD_NS;
  localparam logic [2:0] CFG_HALF_CYC = 3'(CFG_HALF_CYC_INT);
  localparam logic [1:0] MODE_MASTER_SERIAL = 2'h1;
  localparam logic [1:0] MODE_SLAVE_SERIAL = 2'h3;
  localparam logic [3:0] STARTUP_CYCLES = 4'h8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_SAMPLE = 3'h1,
    ST_LOAD = 3'h3,
    ST_STARTUP = 3'h2,
    ST_DONE = 3'h6,
    ST_ERROR = 3'h7
  } scp_state_type;
endpackage

// ===== src/scp_serial_config_port.sv
/*
  Serial configuration port: master and slave serial loading, byte output
  through a two-entry buffer, status pins and daisy-chain output.
  Assumes pins arrive asynchronously and the byte consumer runs on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module scp_serial_config_port (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] mode_i,
  input wire logic cfg_clk_i,
  output logic cfg_clk_o,
  output logic cfg_clk_oe_n_o,
  input wire logic din_i,
  output logic dout_o,
  input wire logic init_i,
  output logic init_o,
  output logic init_oe_n_o,
  output logic done_o,
  output logic done_oe_n_o,
  input wire logic active_status_drive_i,
  output logic chain_select_out_n_o,
  output logic spi_mosi_o,
  input wire logic parallel_cs_n_i,
  input wire logic parallel_dir_i,
  input wire logic crc_error_i,
  input wire logic image_end_i,
  output logic [7:0] byte_o,
  output logic byte_valid_o,
  input wire logic byte_ready_i,
  output logic overrun_o
);
  scp_pkg::scp_state_type state_ff, nxt_state;
  logic cfg_s1_ff, cfg_s2_ff, cfg_s3_ff;
  logic din_s1_ff, din_s2_ff, init_s1_ff, init_s2_ff;
  logic [1:0] mode_s1_ff, mode_s2_ff;
  logic master_ff, cfg_clk_ff, cfg_oe_n_ff, link_prev_ff;
  logic [2:0] div_cnt_ff, bit_cnt_ff;
  logic [3:0] start_cnt_ff;
  logic [6:0] shift_ff;
  logic last_bit_ff, dout_ff, init_oe_n_ff, done_ff, done_o_ff, done_oe_n_ff;
  logic cso_n_ff, mosi_ff, overrun_ff, first_bit_ff;
  logic [7:0] out_ff, spare_ff;
  logic out_valid_ff, spare_valid_ff;

  // Mode decode; parallel strobes left unread in serial modes
  wire mode_ok = (mode_s2_ff == scp_pkg::MODE_MASTER_SERIAL) || (mode_s2_ff == scp_pkg::MODE_SLAVE_SERIAL);
  wire loading = (state_ff == scp_pkg::ST_LOAD);
  wire running = loading || (state_ff == scp_pkg::ST_STARTUP);
  // Slave edges come from the synchronised outside clock
  wire link_lvl = master_ff ? cfg_clk_ff : cfg_s3_ff;
  wire link_rise = link_lvl && !link_prev_ff;
  wire link_fall = !link_lvl && link_prev_ff;
  wire take_bit = loading && link_rise;
  wire [7:0] push_byte = {shift_ff, din_s2_ff};
  wire push = take_bit && (bit_cnt_ff == scp_pkg::BIT_LAST);
  wire pop = out_valid_ff && byte_ready_i;
  wire buf_full = out_valid_ff && spare_valid_ff;
  wire half_end = (div_cnt_ff == scp_pkg::CFG_HALF_CYC - 3'h1);
  wire clk_hold = !cfg_clk_ff && buf_full;
  wire clk_toggle = master_ff && running && half_end && !clk_hold;
  wire start_last = (start_cnt_ff == scp_pkg::STARTUP_CYCLES - 4'h1);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      scp_pkg::ST_INIT: if (init_s2_ff) nxt_state = scp_pkg::ST_SAMPLE;
      scp_pkg::ST_SAMPLE: nxt_state = mode_ok ? scp_pkg::ST_LOAD : scp_pkg::ST_ERROR;
      scp_pkg::ST_LOAD:
      begin
        if (crc_error_i) nxt_state = scp_pkg::ST_ERROR;
        else if (image_end_i) nxt_state = scp_pkg::ST_STARTUP;
      end
      scp_pkg::ST_STARTUP: if (link_rise && start_last) nxt_state = scp_pkg::ST_DONE;
      scp_pkg::ST_DONE: nxt_state = scp_pkg::ST_DONE;
      scp_pkg::ST_ERROR: nxt_state = scp_pkg::ST_ERROR;
      default: nxt_state = scp_pkg::ST_INIT;
    endcase
  end

  // Pin synchronisers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_s1_ff <= 1'b0;
      cfg_s2_ff <= 1'b0;
      cfg_s3_ff <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
      init_s1_ff <= 1'b0;
      init_s2_ff <= 1'b0;
      mode_s1_ff <= 2'h0;
      mode_s2_ff <= 2'h0;
    end
    else
    begin
      cfg_s1_ff <= cfg_clk_i;
      cfg_s2_ff <= cfg_s1_ff;
      cfg_s3_ff <= cfg_s2_ff;
      din_s1_ff <= din_i;
      din_s2_ff <= din_s1_ff;
      init_s1_ff <= init_i;
      init_s2_ff <= init_s1_ff;
      mode_s1_ff <= mode_i;
      mode_s2_ff <= mode_s1_ff;
    end
  end

  // State, mode latch and master clock divider
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= scp_pkg::ST_INIT;
      master_ff <= 1'b0;
      cfg_oe_n_ff <= 1'b1;
      cfg_clk_ff <= 1'b0;
      div_cnt_ff <= 3'h0;
      link_prev_ff <= 1'b0;
      start_cnt_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      link_prev_ff <= link_lvl;
      if (state_ff == scp_pkg::ST_SAMPLE)
      begin
        master_ff <= (mode_s2_ff == scp_pkg::MODE_MASTER_SERIAL);
        cfg_oe_n_ff <= (mode_s2_ff != scp_pkg::MODE_MASTER_SERIAL);
      end
      // Clock stays low until mode latched, stalls when buffer full
      div_cnt_ff <= (!(master_ff && running) || half_end) ? 3'h0 : div_cnt_ff + 3'h1;
      if (clk_toggle) cfg_clk_ff <= !cfg_clk_ff;
      if (state_ff == scp_pkg::ST_STARTUP && link_rise) start_cnt_ff <= start_cnt_ff + 4'h1;
    end
  end

  // Bit assembly, chain outputs and daisy-chain data
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      shift_ff <= 7'h00;
      bit_cnt_ff <= 3'h0;
      last_bit_ff <= 1'b0;
      first_bit_ff <= 1'b0;
      dout_ff <= 1'b0;
      cso_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
    end
    else
    begin
      if (take_bit)
      begin
        shift_ff <= push_byte[6:0];
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        last_bit_ff <= din_s2_ff;
        cso_n_ff <= !cso_n_ff;
        mosi_ff <= !mosi_ff;
        if (bit_cnt_ff == 3'h0) first_bit_ff <= din_s2_ff;
      end
      if (link_fall) dout_ff <= last_bit_ff;
    end
  end

  // Two-entry byte buffer
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_ff <= scp_pkg::BYTE_RESET;
      spare_ff <= scp_pkg::BYTE_RESET;
      out_valid_ff <= 1'b0;
      spare_valid_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (pop)
      begin
        if (spare_valid_ff)
        begin
          out_ff <= spare_ff;
          spare_ff <= push_byte;
          spare_valid_ff <= push;
        end
        else
        begin
          out_ff <= push_byte;
          out_valid_ff <= push;
        end
      end
      else if (push && !out_valid_ff)
      begin
        out_ff <= push_byte;
        out_valid_ff <= 1'b1;
      end
      else if (push && !spare_valid_ff)
      begin
        spare_ff <= push_byte;
        spare_valid_ff <= 1'b1;
      end
      if (push && buf_full && !pop) overrun_ff <= 1'b1;
    end
  end

  // Status pins
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      init_oe_n_ff <= 1'b1;
      done_ff <= 1'b0;
      done_o_ff <= 1'b0;
      done_oe_n_ff <= 1'b0;
    end
    else
    begin
      init_oe_n_ff <= (state_ff != scp_pkg::ST_ERROR);
      done_ff <= (state_ff == scp_pkg::ST_DONE);
      done_o_ff <= active_status_drive_i && done_ff;
      done_oe_n_ff <= !active_status_drive_i && done_ff;
    end
  end

  assign cfg_clk_o = cfg_clk_ff;
  assign cfg_clk_oe_n_o = cfg_oe_n_ff;
  assign dout_o = dout_ff;
  assign init_o = 1'b0;
  assign init_oe_n_o = init_oe_n_ff;
  assign done_o = done_o_ff;
  assign done_oe_n_o = done_oe_n_ff;
  assign chain_select_out_n_o = cso_n_ff;
  assign spi_mosi_o = mosi_ff;
  assign byte_o = out_ff;
  assign byte_valid_o = out_valid_ff;
  assign overrun_o = overrun_ff;

  a_clk_static: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_ff == scp_pkg::ST_INIT || state_ff == scp_pkg::ST_SAMPLE) |-> !cfg_clk_ff && cfg_oe_n_ff)
    else $error("cfg clock moved before mode sampled");
  a_clk_half: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(cfg_clk_ff) |=> cfg_clk_ff [*3])
    else $error("master clock high phase too short");
  a_msb_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
    push |=> spare_valid_ff ? (spare_ff[7] == $past(first_bit_ff) || out_ff[7] == $past(first_bit_ff))
                            : (out_ff[7] == $past(first_bit_ff)))
    else $error("byte not msb first");
  a_bit_count: assert property (@(posedge clk_i) disable iff (!rstn_i)
    take_bit |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
    else $error("bit not taken on rising edge");
  a_sel_toggle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    take_bit |=> chain_select_out_n_o != $past(chain_select_out_n_o) && spi_mosi_o != $past(spi_mosi_o))
    else $error("chain select did not toggle");
  a_dout_fall: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !link_fall |=> dout_o == $past(dout_o))
    else $error("dout changed off falling edge");
  a_init_od: assert property (@(posedge clk_i) disable iff (!rstn_i)
    crc_error_i && loading |-> ##[1:2] !init_oe_n_o && !init_o)
    else $error("crc error not reported on init");
  a_done_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == scp_pkg::ST_DONE && active_status_drive_i |-> ##2 done_o && !done_oe_n_o)
    else $error("done not actively driven high");
  a_done_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff != scp_pkg::ST_DONE |=> !done_ff)
    else $error("done high while unconfigured");
  a_startup_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_ff == scp_pkg::ST_STARTUP && $past(state_ff) == scp_pkg::ST_LOAD |-> start_cnt_ff == 4'h0)
    else $error("startup count not cleared");
endmodule

`default_nettype wire

// ===== verification/scp_src_model.sv
/*
  Serial source model: clock and data from an outside source, or a PROM that answers the device clock.
  Assumes the bench selects the mode and pulses the active-low PROM reset before each run.
*/
`timescale 1ns/1ps
`default_nettype none
module scp_src_model (
  input wire logic master_i,
  input wire logic prom_rst_n_i,
  input wire logic dev_clk_i,
  output logic link_clk_o,
  output logic din_o
);
  logic started = 1'b0;
  initial
  begin
    link_clk_o = 1'b0;
    din_o = 1'b0;
  end
  // PROM reset is active low; it restarts the bit stream
  always @(negedge prom_rst_n_i)
  begin
    started = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      if (master_i)
      begin
        if (started)
          @(negedge dev_clk_i);
        started = 1'b1;
        din_o = b[i];
      end
      else
      begin
        din_o = b[i];
        #100 link_clk_o = 1'b1;
        #100 link_clk_o = 1'b0;
      end
    end
    if (!master_i)
      din_o = ~din_o;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_scp_serial_config_port.sv
/*
  Bench for the serial configuration port: slave, master and error runs.
  Assumes the package, the design and the source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_scp_serial_config_port;
  logic clk_i;
  logic rstn_i;
  logic [1:0] mode_i;
  logic init_pin;
  logic active_status_drive_i;
  logic parallel_cs_n_i;
  logic parallel_dir_i;
  logic crc_error_i;
  logic image_end_i;
  logic byte_ready_i;
  wire logic cfg_clk_i, din_i, init_i, cfg_clk_o, cfg_clk_oe_n_o, dout_o, init_o, init_oe_n_o;
  wire logic done_o, done_oe_n_o, chain_select_out_n_o, spi_mosi_o, byte_valid_o, overrun_o;
  wire logic [7:0] byte_o;
  wire logic done_pin;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int cso_tg = 0;
  assign init_i = (!init_oe_n_o && !init_o) ? 1'b0 : init_pin;
  // Pull-up on the released done pin
  assign done_pin = done_oe_n_o ? 1'b1 : done_o;
  scp_serial_config_port dut (.clk_i, .rstn_i, .mode_i, .cfg_clk_i, .cfg_clk_o, .cfg_clk_oe_n_o, .din_i,
    .dout_o, .init_i, .init_o, .init_oe_n_o, .done_o, .done_oe_n_o, .active_status_drive_i,
    .chain_select_out_n_o, .spi_mosi_o, .parallel_cs_n_i, .parallel_dir_i, .crc_error_i, .image_end_i,
    .byte_o, .byte_valid_o, .byte_ready_i, .overrun_o);
  scp_src_model src (.master_i(mode_i == scp_pkg::MODE_MASTER_SERIAL), .prom_rst_n_i(rstn_i), .dev_clk_i(cfg_clk_o),
    .link_clk_o(cfg_clk_i), .din_o(din_i));
  always #12.5 clk_i = ~clk_i;
  always @(chain_select_out_n_o) cso_tg++;
  always @(posedge clk_i)
  begin
    #1 {parallel_cs_n_i, parallel_dir_i} = {parallel_cs_n_i, parallel_dir_i} + 2'h1;
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pop(input logic [7:0] exp);
    int k;
    k = 0;
    while (byte_valid_o !== 1'b1 && k < 400)
    begin
      step(1);
      k++;
    end
    chk("byte", exp, byte_o);
    byte_ready_i = 1'b1;
    step(1);
    byte_ready_i = 1'b0;
    step(1);
  endtask
  task automatic do_reset(input logic [1:0] m, input logic a);
    rstn_i = 1'b0;
    mode_i = m;
    active_status_drive_i = a;
    init_pin = 1'b0;
    step(20);
    rstn_i = 1'b1;
    cso_tg = 0;
  endtask
  task automatic end_image();
    image_end_i = 1'b1;
    step(1);
    image_end_i = 1'b0;
  endtask
  initial
  begin
    clk_i = 1'b0;
    {parallel_cs_n_i, parallel_dir_i} = 2'h0;
    {crc_error_i, image_end_i, byte_ready_i} = 3'h0;
    do_reset(scp_pkg::MODE_SLAVE_SERIAL, 1'b0);
    chk("done", 8'h00, 8'(done_o));
    src.send_byte(8'hff);
    step(6);
    chk("early_valid", 8'h00, 8'(byte_valid_o));
    chk("clk_dir", 8'h01, 8'(cfg_clk_oe_n_o));
    init_pin = 1'b1;
    step(8);
    src.send_byte(8'haa);
    step(6);
    chk("dout", 8'h00, 8'(dout_o));
    chk("cso_toggles", 8'h08, 8'(cso_tg));
    src.send_byte(8'h5d);
    step(6);
    chk("dout", 8'h01, 8'(dout_o));
    src.send_byte(8'h81);
    step(6);
    chk("overrun", 8'h01, 8'(overrun_o));
    pop(8'haa);
    pop(8'h5d);
    chk("drained", 8'h00, 8'(byte_valid_o));
    end_image();
    src.send_byte(8'h00);
    step(8);
    chk("done_pin", 8'h01, 8'(done_pin));
    chk("done_release", 8'h01, 8'(done_oe_n_o));
    do_reset(scp_pkg::MODE_MASTER_SERIAL, 1'b1);
    step(30);
    chk("clk_static", 8'h00, 8'(cfg_clk_o));
    fork
      begin
        src.send_byte(8'h3c);
        src.send_byte(8'h96);
      end
    join_none
    init_pin = 1'b1;
    pop(8'h3c);
    pop(8'h96);
    chk("cso_active", 8'h01, 8'(cso_tg >= 16));
    chk("clk_drive", 8'h00, 8'(cfg_clk_oe_n_o));
    byte_ready_i = 1'b1;
    end_image();
    step(80);
    chk("done", 8'h01, 8'(done_o));
    chk("done_drive", 8'h00, 8'(done_oe_n_o));
    byte_ready_i = 1'b0;
    do_reset(scp_pkg::MODE_SLAVE_SERIAL, 1'b0);
    init_pin = 1'b1;
    step(8);
    crc_error_i = 1'b1;
    step(1);
    crc_error_i = 1'b0;
    step(2);
    chk("crc_flag", 8'h00, 8'(init_oe_n_o));
    chk("init_level", 8'h00, 8'(init_i));
    chk("done", 8'h00, 8'(done_o));
    conclude();
  end
endmodule
`default_nettype wire
